// *** rtl/iie_cfg.svh ***
`ifndef IIE_CFG_SVH
`define IIE_CFG_SVH

`define IIE_OP_DI 8'h8f
`define IIE_OP_EI 8'h9f
`define IIE_OP_IDLE 8'h6f
`define IIE_OP_IRQ_RETURN_INSTR 8'hbf
`define IIE_OP_INC_REG 8'h20
`define IIE_OP_INC_IND 8'h21
`define IIE_OP_JP_IND 8'h30
`define IIE_LO_INC_R 4'he
`define IIE_LO_JP_CC 4'hd
`define IIE_LO_JR_CC 4'hb

`define IIE_CYC_BASE 4'h4
`define IIE_CYC_IRQ_RETURN_INSTR 4'h6
`define IIE_CYC_JR 4'h6
`define IIE_CYC_JP 4'h8
`define IIE_CYC_VEC 4'h3

`define IIE_LEN_1 16'h0001
`define IIE_LEN_2 16'h0002
`define IIE_LEN_3 16'h0003

`define IIE_SYM_GIE 2
`define IIE_FLAG_C 7
`define IIE_FLAG_Z 6
`define IIE_FLAG_S 5
`define IIE_FLAG_V 4
`define IIE_FLAG_D 3
`define IIE_FLAG_H 2
`define IIE_INC_OVF_IN 8'h7f

`define IIE_WREG_HI 4'hc
`define IIE_VEC_BASE 16'h0000
`define IIE_RST_PC 16'h0100
`define IIE_RST_SP 8'hb0
`define IIE_RST_SYM 8'h00
`define IIE_RST_FLAGS 8'h00

`define IIE_ADR_INSTR 8'h00
`define IIE_ADR_STATUS 8'h04
`define IIE_ADR_PC 8'h08
`define IIE_ADR_FLAGS 8'h0c
`define IIE_ADR_SYM 8'h10
`define IIE_ADR_SP 8'h14
`define IIE_ADR_MADDR 8'h18
`define IIE_ADR_MDATA 8'h1c
`define IIE_ADR_PEND 8'h20

`define IIE_ST_BUSY 0
`define IIE_ST_SLEEP 1
`define IIE_ST_BADOP 2
`define IIE_ST_PEND_LSB 8

`define IIE_RESP_OKAY 2'b00
`define IIE_RESP_SLVERR 2'b10
`define IIE_RESP_DECERR 2'b11

`endif

// *** rtl/iie_pkg.sv ***
package iie_pkg;
    typedef enum logic [1:0] {iie_ready, iie_run, iie_vec, iie_sleep} iie_state_t;
    typedef enum logic [3:0] {
        iie_k_di, iie_k_ei, iie_k_idle, iie_k_inc_r, iie_k_inc_reg, iie_k_inc_ind,
        iie_k_irq_return_instr, iie_k_jp_cc, iie_k_jp_ind, iie_k_jr, iie_k_bad
    } iie_kind_t;
endpackage : iie_pkg

// *** rtl/iie_cond.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "iie_cfg.svh"
module iie_cond
    import iie_pkg::*;
(
    input wire logic [3:0] cond,
    input wire logic [7:0] flags,
    output logic take
);
    logic c, z, s, v, base;
    assign c = flags[`IIE_FLAG_C];
    assign z = flags[`IIE_FLAG_Z];
    assign s = flags[`IIE_FLAG_S];
    assign v = flags[`IIE_FLAG_V];

    // The upper eight codes are the complements of the lower eight.
    always_comb
    begin
        case (cond[2:0])
            3'h0: base = 1'b0;
            3'h1: base = s ^ v;
            3'h2: base = z | (s ^ v);
            3'h3: base = c | z;
            3'h4: base = v;
            3'h5: base = s;
            3'h6: base = z;
            default: base = c;
        endcase
    end
    assign take = base ^ cond[3];
endmodule : iie_cond
`default_nettype wire

// *** rtl/iie_regmem.sv ***
`timescale 1ns/10ps
`default_nettype none
module iie_regmem
    import iie_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 8
)
(
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] ra_addr,
    output logic [DW-1:0] ra_data,
    input wire logic [AW-1:0] rb_addr,
    output logic [DW-1:0] rb_data
);
    if (AW < 1 || DW < 1)
    begin : g_bad_size
        $error("AW and DW must be positive");
    end

    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    // A read in the cycle of a write to the same word returns the old value.
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem_q[waddr] <= wdata;
        end
        ra_data <= mem_q[ra_addr];
        rb_data <= mem_q[rb_addr];
    end
endmodule : iie_regmem
`default_nettype wire

// *** rtl/iie_core.sv ***
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "iie_cfg.svh"
module iie_core
    import iie_pkg::*;
#(
    parameter int N_IRQ = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N_IRQ-1:0] irq_req,
    output logic core_clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    if (N_IRQ < 1 || N_IRQ > 8)
    begin : g_bad_n_irq
        $error("N_IRQ must lie between 1 and 8");
    end

    iie_state_t state_q;
    iie_kind_t kind_w;
    logic [3:0] step_q, cyc_w;
    logic [23:0] instr_q;
    logic [15:0] pc_q, len_w, seq_pc_w, jr_tgt_w, pc_next_w;
    logic [7:0] flags_q, sym_q, sp_q, maddr_q, tgt_q, pch_q, pcl_q;
    logic [7:0] op_w, b2_w, b3_w, inc_base_w, inc_res_w, ma_addr_w, ra_data_w, rb_data_w;
    logic [7:0] mw_addr_w, mw_data_w, pend8_w;
    logic [2:0] vidx_q, pick_w;
    logic [N_IRQ-1:0] pend_w, clr_w;
    logic run_w, done_w, take_w, inc_any_w, inc_wr_w, vec_due_w, vec_end_w, mem_we_w;
    logic bad_q, core_clk_en_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q, rd_w, st_w;
    logic [3:0] wstrb_q;
    logic wr_do_w, bus_ok_w, wr_st_w, start_w, ar_hit_w, aw_hit_w;
    logic sel_instr, sel_pc, sel_flags, sel_sym, sel_sp, sel_maddr, sel_mdata, sel_pend;

    assign op_w = instr_q[7:0];
    assign b2_w = instr_q[15:8];
    assign b3_w = instr_q[23:16];

    assign kind_w = (op_w == `IIE_OP_DI) ? iie_k_di :
        (op_w == `IIE_OP_EI) ? iie_k_ei :
        (op_w == `IIE_OP_IDLE) ? iie_k_idle :
        (op_w == `IIE_OP_IRQ_RETURN_INSTR) ? iie_k_irq_return_instr :
        (op_w == `IIE_OP_INC_REG) ? iie_k_inc_reg :
        (op_w == `IIE_OP_INC_IND) ? iie_k_inc_ind :
        (op_w == `IIE_OP_JP_IND) ? iie_k_jp_ind :
        (op_w[3:0] == `IIE_LO_INC_R) ? iie_k_inc_r :
        (op_w[3:0] == `IIE_LO_JP_CC) ? iie_k_jp_cc :
        (op_w[3:0] == `IIE_LO_JR_CC) ? iie_k_jr : iie_k_bad;

    assign cyc_w = (kind_w == iie_k_jp_cc || kind_w == iie_k_jp_ind) ? `IIE_CYC_JP :
        (kind_w == iie_k_irq_return_instr) ? `IIE_CYC_IRQ_RETURN_INSTR :
        (kind_w == iie_k_jr) ? `IIE_CYC_JR : `IIE_CYC_BASE;
    assign len_w = (kind_w == iie_k_jp_cc) ? `IIE_LEN_3 :
        (kind_w == iie_k_inc_reg || kind_w == iie_k_inc_ind ||
         kind_w == iie_k_jp_ind || kind_w == iie_k_jr) ? `IIE_LEN_2 : `IIE_LEN_1;

    assign run_w = (state_q == iie_run);
    assign done_w = run_w && (step_q == cyc_w - 4'h1);
    assign seq_pc_w = pc_q + len_w;

    iie_cond u_cond (
        .cond(op_w[7:4]),
        .flags(flags_q),
        .take(take_w)
    );

    assign jr_tgt_w = seq_pc_w + {{8{b2_w[7]}}, b2_w};
    assign pc_next_w = (kind_w == iie_k_irq_return_instr || kind_w == iie_k_jp_ind) ? {pch_q, pcl_q} :
        (kind_w == iie_k_jp_cc && take_w) ? {b2_w, b3_w} :
        (kind_w == iie_k_jr && take_w) ? jr_tgt_w : seq_pc_w;

    assign inc_any_w = (kind_w == iie_k_inc_r || kind_w == iie_k_inc_reg ||
        kind_w == iie_k_inc_ind);
    assign inc_base_w = (kind_w == iie_k_inc_r) ? {`IIE_WREG_HI, op_w[7:4]} : b2_w;
    assign inc_res_w = ra_data_w + 8'h01;
    assign inc_wr_w = run_w && inc_any_w && (step_q == 4'h2);

    // Stack reads rely on the pointer moving after the first pop.
    assign ma_addr_w = (inc_any_w && step_q != 4'h0 && kind_w == iie_k_inc_ind) ? ra_data_w :
        inc_any_w ? inc_base_w :
        (kind_w == iie_k_irq_return_instr) ? sp_q + ((step_q == 4'h0) ? 8'h00 : 8'h01) :
        (kind_w == iie_k_jp_ind) ? b2_w + 8'(step_q) : 8'h00;

    assign vec_end_w = (state_q == iie_vec) && (step_q == `IIE_CYC_VEC - 4'h1);
    assign mw_addr_w = (state_q == iie_vec) ? sp_q - 8'(step_q) - 8'h01 :
        inc_wr_w ? tgt_q : maddr_q;
    assign mw_data_w = (state_q == iie_vec) ?
        ((step_q == 4'h0) ? pc_q[7:0] : (step_q == 4'h1) ? pc_q[15:8] : flags_q) :
        inc_wr_w ? inc_res_w : wdata_q[7:0];
    assign mem_we_w = (state_q == iie_vec) || inc_wr_w || (wr_st_w && sel_mdata && wstrb_q[0]);

    iie_regmem #(.AW(8), .DW(8)) u_mem (
        .clk(aclk),
        .we(mem_we_w),
        .waddr(mw_addr_w),
        .wdata(mw_data_w),
        .ra_addr(ma_addr_w),
        .ra_data(ra_data_w),
        .rb_addr(maddr_q),
        .rb_data(rb_data_w)
    );

    for (genvar i = 0; i < N_IRQ; i++)
    begin : g_irq
        logic [2:0] sync_q;
        logic lvl_q, pend_q, rise_w;
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                sync_q <= 3'h0;
                lvl_q <= 1'b0;
                pend_q <= 1'b0;
            end
            else
            begin
                sync_q <= {sync_q[1:0], irq_req[i]};
                lvl_q <= (sync_q[2] == sync_q[1]) ? sync_q[2] : lvl_q;
                pend_q <= rise_w | (pend_q & ~clr_w[i]);
            end
        end
        assign rise_w = (sync_q[2] == sync_q[1]) && sync_q[2] && !lvl_q;
        assign clr_w[i] = (wr_do_w && sel_pend && wstrb_q[0] && wdata_q[i]) ||
            (vec_end_w && vidx_q == 3'(i));
        assign pend_w[i] = pend_q;
    end

    always_comb
    begin
        pick_w = 3'h0;
        for (int k = N_IRQ - 1; k >= 0; k--)
        begin
            if (pend_w[k])
            begin
                pick_w = 3'(k);
            end
        end
    end

    assign vec_due_w = (state_q == iie_ready) && sym_q[`IIE_SYM_GIE] && (|pend_w);

    // Register bus decode.
    assign wr_do_w = !awready_q && !wready_q && !bvalid_q;
    assign bus_ok_w = (state_q == iie_ready) && !vec_due_w;
    assign wr_st_w = wr_do_w && bus_ok_w;
    assign sel_instr = (awaddr_q == `IIE_ADR_INSTR);
    assign sel_pc = (awaddr_q == `IIE_ADR_PC);
    assign sel_flags = (awaddr_q == `IIE_ADR_FLAGS);
    assign sel_sym = (awaddr_q == `IIE_ADR_SYM);
    assign sel_sp = (awaddr_q == `IIE_ADR_SP);
    assign sel_maddr = (awaddr_q == `IIE_ADR_MADDR);
    assign sel_mdata = (awaddr_q == `IIE_ADR_MDATA);
    assign sel_pend = (awaddr_q == `IIE_ADR_PEND);
    assign aw_hit_w = sel_instr || sel_pc || sel_flags || sel_sym || sel_sp || sel_maddr ||
        sel_mdata || sel_pend || (awaddr_q == `IIE_ADR_STATUS);
    assign start_w = wr_st_w && sel_instr;
    assign pend8_w = 8'(pend_w);

    always_comb
    begin
        st_w = 32'h0000_0000;
        st_w[`IIE_ST_BUSY] = (state_q != iie_ready);
        st_w[`IIE_ST_SLEEP] = (state_q == iie_sleep);
        st_w[`IIE_ST_BADOP] = bad_q;
        st_w[`IIE_ST_PEND_LSB +: 8] = pend8_w;
    end

    assign ar_hit_w = (s_axi_araddr <= `IIE_ADR_PEND) && (s_axi_araddr[1:0] == 2'b00);
    assign rd_w = (s_axi_araddr == `IIE_ADR_INSTR) ? {8'h00, instr_q} :
        (s_axi_araddr == `IIE_ADR_STATUS) ? st_w :
        (s_axi_araddr == `IIE_ADR_PC) ? {16'h0000, pc_q} :
        (s_axi_araddr == `IIE_ADR_FLAGS) ? {24'h000000, flags_q} :
        (s_axi_araddr == `IIE_ADR_SYM) ? {24'h000000, sym_q} :
        (s_axi_araddr == `IIE_ADR_SP) ? {24'h000000, sp_q} :
        (s_axi_araddr == `IIE_ADR_MADDR) ? {24'h000000, maddr_q} :
        (s_axi_araddr == `IIE_ADR_MDATA) ? {24'h000000, rb_data_w} :
        (s_axi_araddr == `IIE_ADR_PEND) ? {24'h000000, pend8_w} : 32'h0000_0000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `IIE_RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_q)
            begin
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q)
            begin
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_do_w)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= !aw_hit_w ? `IIE_RESP_DECERR :
                    (bus_ok_w || sel_pend) ? `IIE_RESP_OKAY : `IIE_RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `IIE_RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_w;
            rresp_q <= ar_hit_w ? `IIE_RESP_OKAY : `IIE_RESP_DECERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= iie_ready;
            step_q <= 4'h0;
            vidx_q <= 3'h0;
        end
        else
        begin
            case (state_q)
                iie_ready:
                begin
                    step_q <= 4'h0;
                    vidx_q <= pick_w;
                    state_q <= vec_due_w ? iie_vec : start_w ? iie_run : iie_ready;
                end
                iie_run:
                begin
                    step_q <= step_q + 4'h1;
                    if (done_w)
                    begin
                        state_q <= (kind_w == iie_k_idle) ? iie_sleep : iie_ready;
                    end
                end
                iie_vec:
                begin
                    step_q <= step_q + 4'h1;
                    state_q <= vec_end_w ? iie_ready : iie_vec;
                end
                default:
                begin
                    state_q <= (|pend_w) ? iie_ready : iie_sleep;
                end
            endcase
        end
    end

    // Bus writes to core state are only taken while nothing executes.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            instr_q <= 24'h000000;
            pc_q <= `IIE_RST_PC;
            sp_q <= `IIE_RST_SP;
            maddr_q <= 8'h00;
            bad_q <= 1'b0;
            core_clk_en_q <= 1'b1;
            tgt_q <= 8'h00;
            pch_q <= 8'h00;
            pcl_q <= 8'h00;
        end
        else
        begin
            core_clk_en_q <= (state_q != iie_sleep);
            if (wr_st_w && sel_instr)
            begin
                instr_q[7:0] <= wstrb_q[0] ? wdata_q[7:0] : instr_q[7:0];
                instr_q[15:8] <= wstrb_q[1] ? wdata_q[15:8] : instr_q[15:8];
                instr_q[23:16] <= wstrb_q[2] ? wdata_q[23:16] : instr_q[23:16];
                bad_q <= 1'b0;
            end
            else if (done_w && kind_w == iie_k_bad)
            begin
                bad_q <= 1'b1;
            end
            if (wr_st_w && sel_pc)
            begin
                pc_q[7:0] <= wstrb_q[0] ? wdata_q[7:0] : pc_q[7:0];
                pc_q[15:8] <= wstrb_q[1] ? wdata_q[15:8] : pc_q[15:8];
            end
            else if (done_w)
            begin
                pc_q <= pc_next_w;
            end
            else if (vec_end_w)
            begin
                pc_q <= `IIE_VEC_BASE + {12'h000, vidx_q, 1'b0};
            end
            if (wr_st_w && sel_sp && wstrb_q[0])
            begin
                sp_q <= wdata_q[7:0];
            end
            else if (run_w && kind_w == iie_k_irq_return_instr && step_q == 4'h1)
            begin
                sp_q <= sp_q + 8'h01;
            end
            else if (run_w && kind_w == iie_k_irq_return_instr && step_q == 4'h3)
            begin
                sp_q <= sp_q + 8'h02;
            end
            else if (vec_end_w)
            begin
                sp_q <= sp_q - 8'h03;
            end
            if (wr_st_w && sel_maddr && wstrb_q[0])
            begin
                maddr_q <= wdata_q[7:0];
            end
            if (step_q == 4'h1)
            begin
                tgt_q <= (kind_w == iie_k_inc_ind) ? ra_data_w : inc_base_w;
            end
            if ((kind_w == iie_k_irq_return_instr && step_q == 4'h2) || (kind_w == iie_k_jp_ind && step_q == 4'h1))
            begin
                pch_q <= ra_data_w;
            end
            if ((kind_w == iie_k_irq_return_instr && step_q == 4'h3) || (kind_w == iie_k_jp_ind && step_q == 4'h2))
            begin
                pcl_q <= ra_data_w;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags_q <= `IIE_RST_FLAGS;
            sym_q <= `IIE_RST_SYM;
        end
        else
        begin
            if (wr_st_w && sel_flags && wstrb_q[0])
            begin
                flags_q <= wdata_q[7:0];
            end
            else if (run_w && kind_w == iie_k_irq_return_instr && step_q == 4'h1)
            begin
                flags_q <= ra_data_w;
            end
            else if (inc_wr_w)
            begin
                flags_q[`IIE_FLAG_Z] <= (inc_res_w == 8'h00);
                flags_q[`IIE_FLAG_S] <= inc_res_w[7];
                flags_q[`IIE_FLAG_V] <= (ra_data_w == `IIE_INC_OVF_IN);
            end
            if (wr_st_w && sel_sym && wstrb_q[0])
            begin
                sym_q <= wdata_q[7:0];
            end
            else if ((done_w && kind_w == iie_k_di) || vec_end_w)
            begin
                sym_q[`IIE_SYM_GIE] <= 1'b0;
            end
            else if ((done_w && kind_w == iie_k_ei) || (done_w && kind_w == iie_k_irq_return_instr))
            begin
                sym_q[`IIE_SYM_GIE] <= 1'b1;
            end
        end
    end

    assign core_clk_en = core_clk_en_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_jp_start;
        run_w && step_q == 4'h0 && kind_w == iie_k_jp_cc;
    endsequence
    sequence s_irq_return_instr_done;
        done_w && kind_w == iie_k_irq_return_instr;
    endsequence

    a_di_clears_gie: assert property (done_w && kind_w == iie_k_di |=> !sym_q[`IIE_SYM_GIE])
        else $error("disable left global enable set");
    a_no_vec_off: assert property (state_q == iie_ready && !sym_q[`IIE_SYM_GIE] |=> state_q != iie_vec)
        else $error("vectored while disabled");
    a_ei_sets_gie: assert property (done_w && kind_w == iie_k_ei |=> sym_q[`IIE_SYM_GIE])
        else $error("enable left global enable clear");
    a_pend_serviced: assert property (vec_due_w |=> state_q == iie_vec ##3 state_q == iie_ready)
        else $error("pending request not serviced");
    a_idle_stops: assert property (done_w && kind_w == iie_k_idle |=> ##1 !core_clk_en)
        else $error("idle did not stop core clock");
    a_idle_wake: assert property (state_q == iie_sleep && (|pend_w) |=> state_q == iie_ready)
        else $error("idle not released");
    a_inc_flags: assert property (inc_wr_w |=> flags_q[`IIE_FLAG_Z] == ($past(inc_res_w) == 8'h00)
        && flags_q[`IIE_FLAG_S] == $past(inc_res_w[7]) && $stable(flags_q[`IIE_FLAG_C])
        && $stable(flags_q[`IIE_FLAG_D]) && $stable(flags_q[`IIE_FLAG_H]))
        else $error("increment flags wrong");
    a_inc_ovf: assert property (inc_wr_w |=> flags_q[`IIE_FLAG_V] == ($past(ra_data_w) == 8'h7f))
        else $error("increment overflow wrong");
    a_irq_return_instr_gie: assert property (s_irq_return_instr_done |=> sym_q[`IIE_SYM_GIE] && state_q == iie_ready)
        else $error("return did not enable");
    a_jp_cycles: assert property (s_jp_start |-> (state_q == iie_run) [*8] ##1 state_q == iie_ready)
        else $error("absolute jump cycle count wrong");
    a_jr_target: assert property (done_w && kind_w == iie_k_jr && take_w |=>
        pc_q - $past(pc_q) == 16'h0002 + {{8{$past(b2_w[7])}}, $past(b2_w)})
        else $error("relative jump target wrong");
    a_flags_kept: assert property (run_w && !inc_any_w && kind_w != iie_k_irq_return_instr |=> $stable(flags_q))
        else $error("flags changed");
endmodule : iie_core
`default_nettype wire

// *** test/iie_core_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module iie_core_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] irq_req = 8'h00, awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, clk_en;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [1:0] bresp, rresp, br, rr;
    int bad_count = 0, tests_run = 0, cyc = 0;
    iie_core #(.N_IRQ(8)) iie_core_inst (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req),
        .core_clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    task automatic finish_test;
        if (bad_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    // Generous ceiling; the whole sequence needs well under a tenth of it.
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            bad_count++;
            finish_test;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (awvalid | wvalid)
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        br = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        rd(a);
        chk(n, e, rv);
        chk("rresp", 32'h0, {30'h0, rr});
    endtask : rc
    task automatic mw(input logic [7:0] a, input logic [7:0] d);
        wr(8'h18, {24'h0, a});
        wr(8'h1c, {24'h0, d});
        chk("bresp", 32'h0, {30'h0, br});
    endtask : mw
    task automatic mc(input logic [7:0] a, input logic [7:0] e);
        wr(8'h18, {24'h0, a});
        rc(8'h1c, {24'h0, e}, "mem");
    endtask : mc
    // Busy is already up once the write response has been seen.
    task automatic ex(input logic [31:0] d);
        int n;
        n = 0;
        wr(8'h00, d);
        do
        begin
            rd(8'h04);
            n++;
        end
        while (rv[0] !== 1'b0 && n < 40);
        chk("busy", 32'h0, {31'h0, rv[0]});
    endtask : ex
    task automatic t_rst;
        rc(8'h08, 32'h0100, "pc");
        rc(8'h14, 32'h00b0, "sp");
        rc(8'h10, 32'h0, "sym");
        wr(8'h40, 32'h0);
        chk("bresp", 32'h3, {30'h0, br});
        rd(8'h40);
        chk("rresp", 32'h3, {30'h0, rr});
        ex(32'h01);
        chk("badop", 32'h1, {31'h0, rv[2]});
    endtask : t_rst
    task automatic t_inc;
        wr(8'h0c, 32'h8c);
        mw(8'hc0, 8'h7f);
        ex(32'h0e);
        mc(8'hc0, 8'h80);
        rc(8'h0c, 32'hbc, "flags");
        mw(8'h10, 8'hff);
        ex(32'h1020);
        mc(8'h10, 8'h00);
        rc(8'h0c, 32'hcc, "flags");
        mw(8'h11, 8'h30);
        mw(8'h30, 8'h05);
        ex(32'h1121);
        mc(8'h30, 8'h06);
        rc(8'h0c, 32'h8c, "flags");
    endtask : t_inc
    task automatic t_jmp;
        ex(32'h34128d);
        rc(8'h08, 32'h1234, "pc");
        ex(32'h0d);
        rc(8'h08, 32'h1237, "pc");
        ex(32'h808b);
        rc(8'h08, 32'h11b9, "pc");
        ex(32'h7f0b);
        rc(8'h08, 32'h11bb, "pc");
        mw(8'h40, 8'h56);
        mw(8'h41, 8'h78);
        ex(32'h4030);
        rc(8'h08, 32'h5678, "pc");
        rc(8'h0c, 32'h8c, "flags");
    endtask : t_jmp
    task automatic t_irq;
        ex(32'h9f);
        rc(8'h10, 32'h4, "sym");
        ex(32'h8f);
        rc(8'h10, 32'h0, "sym");
        irq_req <= 8'h02;
        repeat (10) @(posedge aclk);
        rd(8'h04);
        chk("pend", 32'h1, {31'h0, rv[9]});
        rc(8'h08, 32'h567a, "pc");
        ex(32'h9f);
        repeat (10) @(posedge aclk);
        rc(8'h08, 32'h0002, "pc");
        wr(8'h0c, 32'h0);
        ex(32'hbf);
        rc(8'h08, 32'h567b, "pc");
        rc(8'h10, 32'h4, "sym");
        rc(8'h14, 32'hb0, "sp");
        rc(8'h0c, 32'h8c, "flags");
    endtask : t_irq
    task automatic t_idle;
        irq_req <= 8'h00;
        wr(8'h00, 32'h6f);
        repeat (10) @(posedge aclk);
        chk("clk_en", 32'h0, {31'h0, clk_en});
        irq_req <= 8'h01;
        repeat (10) @(posedge aclk);
        chk("clk_en", 32'h1, {31'h0, clk_en});
        wr(8'h00, 32'h6f);
        repeat (10) @(posedge aclk);
        chk("clk_en", 32'h0, {31'h0, clk_en});
        irq_req <= 8'h00;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk("clk_en", 32'h1, {31'h0, clk_en});
        rc(8'h04, 32'h0, "status");
    endtask : t_idle
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_rst;
        t_inc;
        t_jmp;
        t_irq;
        t_idle;
        finish_test;
    end
endmodule : iie_core_tb_top
`default_nettype wire
